/* rtl/nbh_pkg.sv */
// constants and helpers shared by both ends of the byte handshake
// assumes a 250 MHz core clock and negative-logic bus lines
package nbh_pkg;
  // bit positions of the control lines on the bus bundle
  localparam int NBH_LINE_ATN  = 0;
  localparam int NBH_LINE_DAV  = 1;
  localparam int NBH_LINE_NRFD = 2;
  localparam int NBH_LINE_NDAC = 3;
  localparam int NBH_CTL_W     = 4;
  localparam int NBH_DIO_W     = 8;

  localparam int NBH_CLK_PERIOD_NS  = 4;
  localparam int NBH_SETTLE_NS      = 40;
  localparam int NBH_HOLD_NS        = 40;
  localparam int NBH_HSC_GAP_NS     = 200;
  localparam int NBH_HSC_RESP_NS    = 400;
  localparam int NBH_CABLE_NS_PER_M = 10;

  localparam logic [7:0] NBH_CFG_ENABLE_CMD = 8'h1E;
  localparam logic [3:0] NBH_SEC_CFG_GROUP  = 4'h6;
  localparam logic [3:0] NBH_CABLE_NONE     = 4'h0;

  typedef logic [7:0] nbh_cnt_t;

  // least time, rounded up, never below one cycle
  function automatic nbh_cnt_t nbh_cycles(input int ns);
    int c;
    c = (ns + NBH_CLK_PERIOD_NS - 1) / NBH_CLK_PERIOD_NS;
    if (c < 1)
      c = 1;
    return nbh_cnt_t'(c);
  endfunction

  // base delay stretched by the round trip of the configured cable
  function automatic nbh_cnt_t nbh_cable_delay(input int base_ns, input logic [3:0] m);
    return nbh_cycles(base_ns + int'(m) * NBH_CABLE_NS_PER_M);
  endfunction

  localparam nbh_cnt_t NBH_SETTLE_CYC = nbh_cycles(NBH_SETTLE_NS);
  localparam nbh_cnt_t NBH_HOLD_CYC   = nbh_cycles(NBH_HOLD_NS);
endpackage

/* rtl/nbh_bus_if.sv */
// shared open-drain instrument bus between the two ends
// a line is low whenever any party enables a low drive on it
`timescale 1ns/1ps
`default_nettype none
interface nbh_bus_if;
  import nbh_pkg::*;
  logic [NBH_CTL_W-1:0] dev_ctl_o;
  logic [NBH_CTL_W-1:0] dev_ctl_oe;
  logic [NBH_DIO_W-1:0] dev_dio_o;
  logic [NBH_DIO_W-1:0] dev_dio_oe;
  logic [NBH_CTL_W-1:0] oth_ctl_o;
  logic [NBH_CTL_W-1:0] oth_ctl_oe;
  logic [NBH_DIO_W-1:0] oth_dio_o;
  logic [NBH_DIO_W-1:0] oth_dio_oe;
  logic [NBH_CTL_W-1:0] ctl;
  logic [NBH_DIO_W-1:0] dio;

  assign ctl = ~((dev_ctl_oe & ~dev_ctl_o) | (oth_ctl_oe & ~oth_ctl_o));
  assign dio = ~((dev_dio_oe & ~dev_dio_o) | (oth_dio_oe & ~oth_dio_o));

  modport dev_mp (input ctl, input dio, output dev_ctl_o, output dev_ctl_oe, output dev_dio_o, output dev_dio_oe);
  modport oth_mp (input ctl, input dio, output oth_ctl_o, output oth_ctl_oe, output oth_dio_o, output oth_dio_oe);
endinterface
`default_nettype wire

/* rtl/nbh_device_end.sv */
// high-speed talker with extended source handshake and configuration function
// assumes inputs synchronous to core_clk_in; bus levels come from nbh_bus_if
//
// What the two ends do
// - bus lines true when driven low
// - controller addresses, then releases attention first
// - listener asserts NDAC, NRFD, releases NRFD when ready
// - talker waits, then asserts NRFD as capability
// - talker releases NRFD after listener response time
// - talker drives byte, settles, asserts DAV
// - capable listener releases NDAC without NRFD
// - high-speed talker streams bytes without waiting
// - listener latches byte on DAV assertion edge
// - listener buffers at least three bytes
// - each transfer checks capability, else interlocked
// - listener asserting NRFD means interlocked transfer
// - controller sends commands as for standard devices
// - controller sends configuration after power-on
// - pattern 1E under attention arms configuration
// - following 6n stores cable length n
// - capability-message waits follow configured cable length; settle and hold stay fixed
`timescale 1ns/1ps
`default_nettype none
module nbh_device_end
  import nbh_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  nbh_bus_if.dev_mp       bus,
  input  wire logic       talk_en_in,
  input  wire logic       hs_cap_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic            hs_mode_out,
  output logic            cfg_valid_out,
  output logic [3:0]      cable_len_out
);
  typedef enum logic [3:0] {
    NBH_T_IDLE     = 4'h0,
    NBH_T_WAIT_RDY = 4'h1,
    NBH_T_HSC_GAP  = 4'h2,
    NBH_T_HSC_ON   = 4'h3,
    NBH_T_LOAD     = 4'h4,
    NBH_T_SETTLE   = 4'h5,
    NBH_T_DAV_WAIT = 4'h6,
    NBH_T_HS_HOLD  = 4'h7
  } nbh_talk_state_t;

  nbh_talk_state_t state;
  nbh_talk_state_t next_state;
  nbh_cnt_t        cnt;
  nbh_cnt_t        next_cnt;
  logic [7:0]      data;
  logic [7:0]      next_data;
  logic            drive_dav;
  logic            next_drive_dav;
  logic            drive_nrfd;
  logic            next_drive_nrfd;
  logic            hs_try;
  logic            next_hs_try;
  logic            decided;
  logic            next_decided;
  logic            next_hs_mode;
  logic            dav_q;
  logic            cmd_hold;
  logic            cfg_armed;

  // negative logic: a low level means the line is true
  wire       atn         = ~bus.ctl[NBH_LINE_ATN];
  wire       dav         = ~bus.ctl[NBH_LINE_DAV];
  wire       nrfd        = ~bus.ctl[NBH_LINE_NRFD];
  wire       ndac        = ~bus.ctl[NBH_LINE_NDAC];
  wire [7:0] dio_byte    = ~bus.dio;
  wire       dav_edge    = dav & ~dav_q;
  wire       cmd_edge    = atn & dav_edge;
  wire       cnt_done    = (cnt == nbh_cnt_t'(1));
  wire       take        = (state == NBH_T_LOAD) & tx_valid_in & tx_ready_out;
  wire       is_cfg_en   = (dio_byte == NBH_CFG_ENABLE_CMD);
  wire       is_sec_cfg  = (dio_byte[7:4] == NBH_SEC_CFG_GROUP) & (dio_byte[3:0] != NBH_CABLE_NONE);
  wire       try_hs      = hs_cap_in & cfg_valid_out;
  wire       ndac_cmd    = atn & ~cmd_hold & ~cmd_edge;
  // cable-dependent waits around the capability message
  wire nbh_cnt_t gap_cyc  = nbh_cable_delay(NBH_HSC_GAP_NS, cable_len_out);
  wire nbh_cnt_t resp_cyc = nbh_cable_delay(NBH_HSC_RESP_NS, cable_len_out);

  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_data       = data;
    next_drive_dav  = drive_dav;
    next_drive_nrfd = drive_nrfd;
    next_hs_try     = hs_try;
    next_decided    = decided;
    next_hs_mode    = hs_mode_out;
    if (cnt != nbh_cnt_t'(0))
      next_cnt = cnt - nbh_cnt_t'(1);
    case (state)
      NBH_T_IDLE:
      begin
        if (talk_en_in & ~atn)
          next_state = NBH_T_WAIT_RDY;
      end
      NBH_T_WAIT_RDY:
      begin
        // capability check opens every transfer
        next_hs_mode = 1'b0;
        next_hs_try  = try_hs;
        next_decided = ~try_hs;
        if (~nrfd)
        begin
          next_state = try_hs ? NBH_T_HSC_GAP : NBH_T_LOAD;
          next_cnt   = gap_cyc;
        end
      end
      NBH_T_HSC_GAP:
      begin
        if (cnt_done)
        begin
          next_drive_nrfd = 1'b1;
          next_cnt        = resp_cyc;
          next_state      = NBH_T_HSC_ON;
        end
      end
      NBH_T_HSC_ON:
      begin
        if (cnt_done)
        begin
          next_drive_nrfd = 1'b0;
          next_state      = NBH_T_LOAD;
        end
      end
      NBH_T_LOAD:
      begin
        if (take)
        begin
          next_data  = tx_data_in;
          next_cnt   = NBH_SETTLE_CYC;
          next_state = NBH_T_SETTLE;
        end
      end
      NBH_T_SETTLE:
      begin
        // interlocked bytes still wait for the listener to be ready
        if ((cnt == nbh_cnt_t'(0)) & (hs_mode_out | ~nrfd))
        begin
          next_drive_dav = 1'b1;
          next_cnt       = NBH_HOLD_CYC;
          next_state     = hs_mode_out ? NBH_T_HS_HOLD : NBH_T_DAV_WAIT;
        end
      end
      NBH_T_DAV_WAIT:
      begin
        if (~decided & nrfd)
          next_decided = 1'b1;
        else if (~ndac)
        begin
          next_decided = 1'b1;
          next_hs_mode = ~decided & hs_try;
          if (~decided & hs_try)
            next_state = NBH_T_HS_HOLD;
          else
          begin
            next_drive_dav = 1'b0;
            next_state     = NBH_T_LOAD;
          end
        end
      end
      NBH_T_HS_HOLD:
      begin
        // no wait on the listener while streaming
        if (cnt == nbh_cnt_t'(0))
        begin
          next_drive_dav = 1'b0;
          next_state     = NBH_T_LOAD;
        end
      end
      default:
        next_state = NBH_T_IDLE;
    endcase
    if (atn | ~talk_en_in)
    begin
      next_state      = NBH_T_IDLE;
      next_drive_dav  = 1'b0;
      next_drive_nrfd = 1'b0;
      next_hs_mode    = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state        <= NBH_T_IDLE;
      cnt          <= '0;
      data         <= '0;
      drive_dav    <= 1'b0;
      drive_nrfd   <= 1'b0;
      hs_try       <= 1'b0;
      decided      <= 1'b0;
      hs_mode_out  <= 1'b0;
      tx_ready_out <= 1'b0;
    end
    else if (ce_in)
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      data         <= next_data;
      drive_dav    <= next_drive_dav;
      drive_nrfd   <= next_drive_nrfd;
      hs_try       <= next_hs_try;
      decided      <= next_decided;
      hs_mode_out  <= next_hs_mode;
      tx_ready_out <= (next_state == NBH_T_LOAD) & ~take;
    end
  end

  // configuration function; commands acknowledged like any standard device
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dav_q         <= 1'b0;
      cmd_hold      <= 1'b0;
      cfg_armed     <= 1'b0;
      cfg_valid_out <= 1'b0;
      cable_len_out <= NBH_CABLE_NONE;
    end
    else if (ce_in)
    begin
      dav_q    <= dav;
      cmd_hold <= atn & (cmd_edge | (cmd_hold & dav));
      if (cmd_edge)
      begin
        cfg_armed <= is_cfg_en;
        if (cfg_armed & is_sec_cfg)
        begin
          cable_len_out <= dio_byte[3:0];
          cfg_valid_out <= 1'b1;
        end
      end
    end
  end

  // open-drain drives: enable pulls the line low, i.e. true
  assign bus.dev_ctl_o  = '0;
  assign bus.dev_dio_o  = '0;
  assign bus.dev_dio_oe = (state == NBH_T_IDLE) ? 8'h00 : data;
  always_comb
  begin
    bus.dev_ctl_oe                = '0;
    bus.dev_ctl_oe[NBH_LINE_DAV]  = drive_dav;
    bus.dev_ctl_oe[NBH_LINE_NRFD] = drive_nrfd;
    bus.dev_ctl_oe[NBH_LINE_NDAC] = ndac_cmd;
  end
endmodule
`default_nettype wire

/* rtl/nbh_other_end.sv */
// far end: standby-capable controller plus extended acceptor listener
// assumes inputs synchronous to core_clk_in; bus levels come from nbh_bus_if
`timescale 1ns/1ps
`default_nettype none
module nbh_other_end
  import nbh_pkg::*;
#(
  parameter int DEPTH = 3
)
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  nbh_bus_if.oth_mp       bus,
  input  wire logic       atn_req_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic       lsn_en_in,
  input  wire logic       lsn_hs_cap_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic            lsn_hs_mode_out,
  output logic            rx_overflow_out
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef enum logic [1:0] {
    NBH_C_IDLE   = 2'h0,
    NBH_C_SETTLE = 2'h1,
    NBH_C_DAV    = 2'h2
  } nbh_ctl_state_t;
  typedef enum logic [1:0] {
    NBH_L_IDLE  = 2'h0,
    NBH_L_READY = 2'h1,
    NBH_L_HS    = 2'h2,
    NBH_L_ACC   = 2'h3
  } nbh_lsn_state_t;

  function automatic logic [PW-1:0] nbh_wrap(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  nbh_ctl_state_t c_state;
  nbh_lsn_state_t l_state;
  nbh_cnt_t       c_cnt;
  logic [7:0]     c_data;
  logic           c_atn;
  logic           c_dav;
  logic           l_ndac;
  logic           l_nrfd;
  logic           hsc_seen;
  logic           dav_q;
  logic [7:0]     mem [DEPTH];
  logic [PW-1:0]  wr_ptr;
  logic [PW-1:0]  rd_ptr;
  logic [CW-1:0]  count;

  wire dav  = ~bus.ctl[NBH_LINE_DAV];
  wire nrfd = ~bus.ctl[NBH_LINE_NRFD];
  wire ndac = ~bus.ctl[NBH_LINE_NDAC];
  wire [7:0] dio_byte = ~bus.dio;
  wire dav_edge  = dav & ~dav_q;
  wire l_active  = lsn_en_in & ~c_atn;
  wire full      = (count == CW'(DEPTH));
  // byte latched on the DAV assertion edge
  wire push      = l_active & dav_edge & ((l_state == NBH_L_READY) | (l_state == NBH_L_HS));
  wire pop       = (count != '0) & (~rx_valid_out | rx_ready_in);
  wire wr_ok     = push & ~full;
  wire cmd_take  = (c_state == NBH_C_IDLE) & c_atn & cmd_valid_in & cmd_ready_out;

  // controller: commands go out with the plain interlocked handshake
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      c_state       <= NBH_C_IDLE;
      c_cnt         <= '0;
      c_data        <= '0;
      c_atn         <= 1'b0;
      c_dav         <= 1'b0;
      cmd_ready_out <= 1'b0;
    end
    else if (ce_in)
    begin
      cmd_ready_out <= 1'b0;
      if (c_cnt != nbh_cnt_t'(0))
        c_cnt <= c_cnt - nbh_cnt_t'(1);
      case (c_state)
        NBH_C_IDLE:
        begin
          c_atn         <= atn_req_in;
          cmd_ready_out <= c_atn & atn_req_in & ~cmd_take;
          if (cmd_take)
          begin
            c_data  <= cmd_data_in;
            c_cnt   <= NBH_SETTLE_CYC;
            c_state <= NBH_C_SETTLE;
          end
        end
        NBH_C_SETTLE:
        begin
          if ((c_cnt == nbh_cnt_t'(0)) & ~nrfd)
          begin
            c_dav   <= 1'b1;
            c_state <= NBH_C_DAV;
          end
        end
        NBH_C_DAV:
        begin
          if (~ndac)
          begin
            c_dav   <= 1'b0;
            c_state <= NBH_C_IDLE;
          end
        end
        default:
          c_state <= NBH_C_IDLE;
      endcase
    end
  end

  // extended acceptor handshake
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      l_state         <= NBH_L_IDLE;
      l_ndac          <= 1'b0;
      l_nrfd          <= 1'b0;
      hsc_seen        <= 1'b0;
      dav_q           <= 1'b0;
      lsn_hs_mode_out <= 1'b0;
      rx_overflow_out <= 1'b0;
    end
    else if (ce_in)
    begin
      dav_q <= dav;
      // streaming gives no back-pressure, so a full buffer drops and flags
      if (push & full)
        rx_overflow_out <= 1'b1;
      case (l_state)
        NBH_L_IDLE:
        begin
          lsn_hs_mode_out <= 1'b0;
          hsc_seen        <= 1'b0;
          if (l_active)
          begin
            l_ndac          <= 1'b1;
            l_nrfd          <= 1'b1;
            rx_overflow_out <= push & full;
            l_state         <= NBH_L_READY;
          end
        end
        NBH_L_READY:
        begin
          l_nrfd <= full;
          // NRFD held low by someone else after our release is the capability message
          if (lsn_hs_cap_in & ~l_nrfd & nrfd & ~dav)
            hsc_seen <= 1'b1;
          if (push)
          begin
            l_ndac <= 1'b0;
            if (hsc_seen)
            begin
              lsn_hs_mode_out <= 1'b1;
              l_state         <= NBH_L_HS;
            end
            else
            begin
              l_nrfd  <= 1'b1;
              l_state <= NBH_L_ACC;
            end
          end
        end
        NBH_L_ACC:
        begin
          if (~dav)
          begin
            l_ndac  <= 1'b1;
            l_state <= NBH_L_READY;
          end
        end
        NBH_L_HS:
          l_nrfd <= 1'b0;
        default:
          l_state <= NBH_L_IDLE;
      endcase
      if (~l_active)
      begin
        l_state <= NBH_L_IDLE;
        l_ndac  <= 1'b0;
        l_nrfd  <= 1'b0;
      end
    end
  end

  // receive buffer of DEPTH bytes
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      rx_valid_out <= 1'b0;
      rx_data_out  <= '0;
    end
    else if (ce_in)
    begin
      if (wr_ok)
        wr_ptr <= nbh_wrap(wr_ptr);
      if (pop)
      begin
        rd_ptr       <= nbh_wrap(rd_ptr);
        rx_data_out  <= mem[rd_ptr];
        rx_valid_out <= 1'b1;
      end
      else if (rx_ready_in)
        rx_valid_out <= 1'b0;
      count <= count + CW'(wr_ok) - CW'(pop);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (ce_in & wr_ok)
      mem[wr_ptr] <= dio_byte;
  end

  assign bus.oth_ctl_o  = '0;
  assign bus.oth_dio_o  = '0;
  assign bus.oth_dio_oe = (c_state == NBH_C_IDLE) ? 8'h00 : c_data;
  always_comb
  begin
    bus.oth_ctl_oe                = '0;
    bus.oth_ctl_oe[NBH_LINE_ATN]  = c_atn;
    bus.oth_ctl_oe[NBH_LINE_DAV]  = c_dav;
    bus.oth_ctl_oe[NBH_LINE_NRFD] = l_nrfd;
    bus.oth_ctl_oe[NBH_LINE_NDAC] = l_ndac;
  end
endmodule
`default_nettype wire

/* verification/nbh_asserts.sv */
// concurrent checks on the shared handshake bus
// assumes signals taken straight from nbh_bus_if, one clock domain
`timescale 1ns/1ps
`default_nettype none
module nbh_checker
  import nbh_pkg::*;
(
  input wire logic                 core_clk_in,
  input wire logic                 reset_n_in,
  input wire logic [NBH_CTL_W-1:0] ctl,
  input wire logic [NBH_DIO_W-1:0] dio,
  input wire logic [NBH_CTL_W-1:0] dev_ctl_o,
  input wire logic [NBH_CTL_W-1:0] dev_ctl_oe,
  input wire logic [NBH_CTL_W-1:0] oth_ctl_o
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // talker takes NRFD itself in data mode: the capability pulse
  sequence s_hsc_on;
    $rose(dev_ctl_oe[NBH_LINE_NRFD]) && ctl[NBH_LINE_ATN];
  endsequence
  sequence s_dav_on;
    $fell(ctl[NBH_LINE_DAV]);
  endsequence

  a_neg_drive: assert property ((dev_ctl_o | oth_ctl_o) == 4'h0)
    else $error("control line driven high");
  a_dev_no_atn: assert property (dev_ctl_oe[NBH_LINE_ATN] == 1'b0)
    else $error("talker end drove attention");
  a_hsc_wait: assert property (s_hsc_on |-> $past(ctl[NBH_LINE_NRFD]) && $past(ctl[NBH_LINE_NRFD], 40))
    else $error("capability pulse before listener ready");
  a_hsc_release: assert property (s_hsc_on |-> ctl[NBH_LINE_DAV] throughout
                                  (##[90:150] !dev_ctl_oe[NBH_LINE_NRFD]))
    else $error("capability pulse not released in time");
  a_hsc_width: assert property ($fell(dev_ctl_oe[NBH_LINE_NRFD]) && ctl[NBH_LINE_ATN]
                                |-> $past(dev_ctl_oe[NBH_LINE_NRFD], 90))
    else $error("capability pulse too short");
  a_dav_settle: assert property (s_dav_on |-> $stable(dio) && dio == $past(dio, 9))
    else $error("data not settled before valid");
  a_dav_ready: assert property (s_dav_on |-> $past(ctl[NBH_LINE_NRFD]))
    else $error("valid asserted while listener not ready");
  a_dio_hold: assert property (!ctl[NBH_LINE_DAV] && $past(!ctl[NBH_LINE_DAV]) |-> $stable(dio))
    else $error("data moved while valid asserted");
  a_cmd_ack: assert property (s_dav_on and !ctl[NBH_LINE_ATN] |-> ##[1:3] !dev_ctl_oe[NBH_LINE_NDAC])
    else $error("command not accepted");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench: both handshake ends joined by the shared bus
// assumes a 4 ns core clock; no other parties on the bus
`timescale 1ns/1ps
`default_nettype none
module testbench
  import nbh_pkg::*;
;
  localparam int DEPTH = 3;
  logic       clk = 1'b0;
  logic       reset_n, atn_req, cmd_valid, talk_en, hs_cap, tx_valid, lsn_en, lsn_hs_cap, rx_ready;
  logic [7:0] cmd_data, tx_data, rx_data;
  logic       tx_ready, hs_mode, cfg_valid, cmd_ready, rx_valid, lsn_hs_mode, rx_overflow;
  logic [3:0] cable_len;
  logic       hs_seen, lhs_seen;
  logic       ce, ce_rand;
  logic [7:0] exp_q[$];
  int         failures, total_checks, seed, pulse_cnt, pulse_w, last_w, cfg_n, n;

  always #2 clk = ~clk;

  nbh_bus_if nbh_bus_if_inst ();
  nbh_device_end nbh_device_end_inst (.core_clk_in(clk), .reset_n_in(reset_n), .ce_in(ce),
    .bus(nbh_bus_if_inst), .talk_en_in(talk_en), .hs_cap_in(hs_cap), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .hs_mode_out(hs_mode),
    .cfg_valid_out(cfg_valid), .cable_len_out(cable_len));
  nbh_other_end #(.DEPTH(DEPTH)) nbh_other_end_inst (.core_clk_in(clk), .reset_n_in(reset_n),
    .ce_in(ce), .bus(nbh_bus_if_inst), .atn_req_in(atn_req), .cmd_data_in(cmd_data),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .lsn_en_in(lsn_en),
    .lsn_hs_cap_in(lsn_hs_cap), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .lsn_hs_mode_out(lsn_hs_mode), .rx_overflow_out(rx_overflow));
  nbh_checker nbh_checker_inst (.core_clk_in(clk), .reset_n_in(reset_n), .ctl(nbh_bus_if_inst.ctl),
    .dio(nbh_bus_if_inst.dio), .dev_ctl_o(nbh_bus_if_inst.dev_ctl_o),
    .dev_ctl_oe(nbh_bus_if_inst.dev_ctl_oe), .oth_ctl_o(nbh_bus_if_inst.oth_ctl_o));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one clock of a bounded wait; running out ends the run
  task automatic step(inout int k, input string what);
    @(posedge clk);
    k++;
    if (k > 3000)
    begin
      failures++;
      $display("MISMATCH %s expected done seen timeout", what);
      finish_test();
    end
  endtask

  // random freezes of both ends, only where no timed pulse is measured
  always @(posedge clk)
    ce <= !(ce_rand && (($random(seed) & 3) == 0));

  // listener side: each delivered byte against the oldest note
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && ce === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("rx_count", 8'h00, 8'h01);
      else
        check("rx_data", exp_q.pop_front(), rx_data);
    end
    hs_seen = hs_seen | hs_mode;
    lhs_seen = lhs_seen | lsn_hs_mode;
    if (nbh_bus_if_inst.dev_ctl_oe[NBH_LINE_NRFD] === 1'b1)
      pulse_w++;
    else if (pulse_w != 0)
    begin
      last_w = pulse_w;
      pulse_cnt++;
      pulse_w = 0;
    end
  end

  task automatic reset_dut();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("cfg_valid", 8'h00, 8'(cfg_valid));
    check("cable_len", 8'h00, 8'(cable_len));
    check("rx_overflow", 8'h00, 8'(rx_overflow));
    $display("reset done");
  endtask

  // commands under attention, held back to back
  task automatic send_cmds(input string name, input logic [7:0] c [3], input int cnt);
    int k;
    @(posedge clk);
    atn_req <= 1'b1;
    k = 0;
    while (nbh_bus_if_inst.ctl[NBH_LINE_ATN] !== 1'b0) step(k, "atn_on");
    for (int i = 0; i < cnt; i++)
    begin
      cmd_data <= c[i];
      cmd_valid <= 1'b1;
      k = 0;
      do step(k, "cmd_ready"); while (cmd_ready !== 1'b1);
    end
    cmd_valid <= 1'b0;
    k = 0;
    do step(k, "cmd_dav"); while (nbh_bus_if_inst.ctl[NBH_LINE_DAV] !== 1'b0);
    while (cmd_ready !== 1'b1) step(k, "cmd_done");
    atn_req <= 1'b0;
    while (nbh_bus_if_inst.ctl[NBH_LINE_ATN] !== 1'b1) step(k, "atn_off");
    $display("%s done", name);
  endtask

  task automatic xfer(input string name, input int cnt, input logic ht, input logic hl, input logic stall);
    int k;
    int p0;
    logic [7:0] d;
    logic hs_exp;
    @(negedge clk);
    hs_seen = 1'b0;
    lhs_seen = 1'b0;
    p0 = pulse_cnt;
    hs_exp = ht & hl & (cfg_n != 0);
    @(posedge clk);
    lsn_en <= 1'b1;
    lsn_hs_cap <= hl;
    hs_cap <= ht;
    rx_ready <= !stall;
    talk_en <= 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      d = 8'($random(seed));
      if (!stall || i <= DEPTH)
        exp_q.push_back(d);
      tx_data <= d;
      tx_valid <= 1'b1;
      k = 0;
      do step(k, "tx_ready"); while (tx_ready !== 1'b1 || ce !== 1'b1);
    end
    tx_valid <= 1'b0;
    k = 0;
    if (stall)
    begin
      // stalled reader: fifo plus output register fill, the rest drop
      while (rx_overflow !== 1'b1) step(k, "overflow");
      repeat (2 * (NBH_SETTLE_CYC + NBH_HOLD_CYC)) @(posedge clk);
      rx_ready <= 1'b1;
    end
    while (exp_q.size() != 0) step(k, "rx_drain");
    check("hs_mode", 8'(hs_exp), 8'(hs_seen));
    check("lsn_hs_mode", 8'(hs_exp), 8'(lhs_seen));
    check("hsc_count", 8'(ht && cfg_n != 0), 8'(pulse_cnt - p0));
    if (ht && cfg_n != 0)
      check("hsc_width", 8'((NBH_HSC_RESP_NS + cfg_n * NBH_CABLE_NS_PER_M + NBH_CLK_PERIOD_NS - 1)
                            / NBH_CLK_PERIOD_NS), 8'(last_w));
    @(posedge clk);
    talk_en <= 1'b0;
    lsn_en <= 1'b0;
    k = 0;
    do step(k, "bus_idle"); while (nbh_bus_if_inst.ctl !== 4'hF);
    $display("%s done", name);
  endtask

  initial
  begin
    {reset_n, atn_req, cmd_valid, talk_en, hs_cap, tx_valid, lsn_en, lsn_hs_cap, rx_ready} = '0;
    cmd_data = 8'h00;
    tx_data = 8'h00;
    {hs_seen, lhs_seen} = '0;
    ce = 1'b1;
    ce_rand = 1'b0;
    {failures, total_checks, pulse_cnt, pulse_w, last_w, cfg_n} = '0;
    seed = 70;
    reset_dut();
    xfer("unconfigured", 4, 1'b1, 1'b1, 1'b0);
    send_cmds("lone secondary", '{8'h63, 8'h00, 8'h00}, 1);
    check("cfg_valid", 8'h00, 8'(cfg_valid));
    n = 1 + ($unsigned($random(seed)) % 15);
    send_cmds("broken pair", '{8'h1E, 8'h3F, 8'h60 | 8'(n)}, 3);
    check("cfg_valid", 8'h00, 8'(cfg_valid));
    send_cmds("configure", '{8'h1E, 8'h60 | 8'(n), 8'h00}, 2);
    cfg_n = n;
    check("cfg_valid", 8'h01, 8'(cfg_valid));
    check("cable_len", 8'(n), 8'(cable_len));
    xfer("both fast", 8, 1'b1, 1'b1, 1'b0);
    xfer("slow listener", 5, 1'b1, 1'b0, 1'b0);
    ce_rand = 1'b1;
    xfer("slow talker", 5, 1'b0, 1'b1, 1'b0);
    ce_rand = 1'b0;
    xfer("stalled reader", 6, 1'b1, 1'b1, 1'b1);
    reset_dut();
    cfg_n = 0;
    xfer("after reset", 3, 1'b1, 1'b1, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
